// ===== hdl/affc_pkg.sv
// Constants, register map and helpers for the analog fault flag unit.
// Assumes a byte-addressed classic Wishbone slave port with 32-bit data.
package affc_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_SYS_CLR = 8'h14;
    localparam logic [7:0] ADDR_SYS_STS = 8'h18;
    localparam logic [7:0] ADDR_SUP_STS = 8'h1c;
    localparam logic [7:0] ADDR_SUP_EN = 8'h20;
    localparam logic [7:0] ADDR_SUP_CLR = 8'h24;
    localparam logic [7:0] ADDR_SYS_EN = 8'h28;
    localparam logic [7:0] ADDR_BRG_CLR = 8'h54;
    localparam logic [7:0] ADDR_BRG_STS = 8'h58;
    localparam logic [7:0] ADDR_BRG_EN = 8'h5c;
    localparam logic [7:0] ADDR_SUM = 8'h60;
    localparam logic [7:0] ADDR_SUM_MASK = 8'h64;

    // Analog module flag fields
    localparam int SYS_W = 16;
    localparam logic [15:0] SYS_IMPL = 16'h0fc7;
    localparam int SYS_REF_MSB = 11;
    localparam int SYS_REF_LSB = 10;
    localparam int SYS_TEMP_MSB = 9;
    localparam int SYS_TEMP_LSB = 6;
    localparam int SYS_LIN_MSB = 2;
    localparam int SYS_LIN_LSB = 0;

    // Bridge driver fields
    localparam int THR_W = 5;
    localparam int THR_STS_LSB = 24;
    localparam int THR_STS_MSB = 28;
    localparam int THR_IS_LSB = 16;
    localparam int THR_IS_MSB = 20;
    localparam int FET_W = 4;
    localparam int OC_LSB = 10;
    localparam int OC_MSB = 13;
    localparam int SHORT_LSB = 0;
    localparam int SHORT_MSB = 3;
    localparam logic [31:0] BRG_STS_RESET = 32'h00000030;
    localparam logic [31:0] BRG_RSVD = 32'he0e0c3c0;
    localparam logic [31:0] BRG_EN_IMPL = 32'h001f3c0f;

    // Supply fields
    localparam int SUP_W = 8;
    localparam int SUP_STS_LSB = 16;
    localparam int SUP_STS_MSB = 23;
    localparam int SUP_IS_LSB = 0;
    localparam int SUP_IS_MSB = 7;
    localparam logic [7:0] SUP_EN_RESET = 8'hff;

    // Event summary
    localparam int SUM_W = 3;
    localparam int SUM_SYS = 0;
    localparam int SUM_BRG = 1;
    localparam int SUM_SUP = 2;

    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    function automatic logic addr_hit(input logic [7:0] adr, input logic [7:0] reg_adr);
        addr_hit = (adr[7:2] == reg_adr[7:2]);
    endfunction

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = WORD_ZERO;
        for (int i = 0; i < 4; i++) begin
            lane_mask[i*8 +: 8] = {8{sel[i]}};
        end
    endfunction
endpackage : affc_pkg

// ===== hdl/affc_flag_bank.sv
// Bank of sticky fault flags, set by edge or by level of a condition.
// Assumes conditions are synchronous to mclk_i.
module affc_flag_bank #(
    parameter int W = 4,
    parameter bit EDGE = 1'b1
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Condition and clear
    input wire logic [W-1:0] cond_i,
    input wire logic [W-1:0] clr_i,
    // Flags
    output logic [W-1:0] flags_o,
    output logic [W-1:0] set_o
);
    logic [W-1:0] prev_q;
    logic [W-1:0] flags_q;

    // Edge mode ignores a condition that simply stays high
    assign set_o = EDGE ? (cond_i & ~prev_q) : cond_i;
    assign flags_o = flags_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            prev_q <= '0;
        end else begin
            prev_q <= cond_i;
        end
    end

    // Set beats clear so a coincident event survives
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~clr_i) | set_o;
        end
    end
endmodule // affc_flag_bank

// ===== hdl/affc_wb_slave.sv
// Classic Wishbone handshake: one wait state, ack for one cycle.
// Assumes the master holds its request until it samples ack.
module affc_wb_slave (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    // Access strobes
    output logic req_o,
    output logic acc_o
);
    logic ack_q;

    assign wb_ack_o = ack_q;
    assign req_o = wb_cyc_i & wb_stb_i & ~ack_q;
    // Effects happen on the edge where the master sees ack
    assign acc_o = wb_cyc_i & wb_stb_i & ack_q;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req_o;
        end
    end
endmodule // affc_wb_slave

// ===== hdl/affc_unit.sv
// Analog fault flag bank with write-one-to-clear registers and interrupts.
// Assumes a classic Wishbone master and conditions synchronous to mclk_i.
// Function
// - Writing one to bits 9..6 clears temperature shutdown and prewarning flags.
// - Writing one to bits 11..10 clears reference over and under flags.
// - Writing one to bits 2..0 clears LIN timeout, overheat, overcurrent flags.
// - Bridge bits 28..24 report drain and pump threshold warnings.
// - Bridge bits 20..16 hold interrupt flags for those five warnings.
// - Bridge bits 13..10 flag external transistor overcurrent.
// - Bridge bits 3..0 flag pre-driver short faults.
// - Writing one to bridge clear bits 28..24 clears threshold status flags.
// - Writing one to bridge clear bits 20..16 clears threshold interrupt flags.
// - Writing one to bridge clear bits 13..10 clears overcurrent flags.
// - Writing one to bridge clear bits 3..0 clears short flags.
// - Supply status bits 23..20 show overvoltage of four supplies.
// - Supply status bits 19..16 show undervoltage of four supplies.
// - Bridge reserved bits read as zero.
// - Interrupt flags set on condition edge; threshold status set by level, held until cleared; supply status follows condition.
// - Module interrupt only when flag and its enable bit are set.
//
// Chosen here: the Wishbone register port.
module affc_unit
    import affc_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Fault conditions
    input wire logic [15:0] sys_cond_i,
    input wire logic [4:0] thr_cond_i,
    input wire logic [3:0] fet_oc_i,
    input wire logic [3:0] predrv_short_i,
    input wire logic [3:0] supply_over_i,
    input wire logic [3:0] supply_under_i,
    // Interrupts
    output logic analog_irq_o,
    output logic bridge_irq_o,
    output logic supply_irq_o,
    output logic irq_o
);
    logic req;
    logic acc;
    logic wr;
    logic rd;
    logic [31:0] wm;
    logic [31:0] lm;
    logic [31:0] rd_data;
    logic [31:0] dat_q;
    logic [31:0] brg_word;

    logic [SYS_W-1:0] sys_clr;
    logic [SYS_W-1:0] sys_flags;
    logic [SYS_W-1:0] sys_set;
    logic [SYS_W-1:0] sys_en_q;

    logic [THR_W-1:0] thr_sts_clr;
    logic [THR_W-1:0] thr_sts;
    logic [THR_W-1:0] thr_sts_set;
    logic [THR_W-1:0] thr_is_clr;
    logic [THR_W-1:0] thr_is;
    logic [THR_W-1:0] thr_set;
    logic [FET_W-1:0] oc_clr;
    logic [FET_W-1:0] oc_flags;
    logic [FET_W-1:0] oc_set;
    logic [FET_W-1:0] short_clr;
    logic [FET_W-1:0] short_flags;
    logic [FET_W-1:0] short_set;
    logic [31:0] brg_en_q;

    logic [SUP_W-1:0] sup_cond;
    logic [SUP_W-1:0] sup_sts_q;
    logic [SUP_W-1:0] sup_clr;
    logic [SUP_W-1:0] sup_is;
    logic [SUP_W-1:0] sup_set;
    logic [SUP_W-1:0] sup_en_q;

    logic [SUM_W-1:0] sum_q;
    logic [SUM_W-1:0] sum_set;
    logic [SUM_W-1:0] sum_clr;
    logic [SUM_W-1:0] sum_mask_q;
    logic analog_irq_q;
    logic bridge_irq_q;
    logic supply_irq_q;
    logic irq_q;

    affc_wb_slave u_bus (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o),
        .req_o(req),
        .acc_o(acc)
    );

    assign wr = acc & wb_we_i;
    assign rd = acc & ~wb_we_i;
    // Unselected byte lanes never clear anything
    assign lm = lane_mask(wb_sel_i);
    assign wm = wb_dat_i & lm;

    // Write-one clears of the analog module flags
    always_comb begin
        sys_clr = '0;
        if (wr && addr_hit(wb_adr_i, ADDR_SYS_CLR)) begin
            sys_clr[SYS_TEMP_MSB:SYS_TEMP_LSB] = wm[SYS_TEMP_MSB:SYS_TEMP_LSB];
            sys_clr[SYS_REF_MSB:SYS_REF_LSB] = wm[SYS_REF_MSB:SYS_REF_LSB];
            sys_clr[SYS_LIN_MSB:SYS_LIN_LSB] = wm[SYS_LIN_MSB:SYS_LIN_LSB];
        end
    end

    // Write-one clears of the bridge driver flags
    always_comb begin
        thr_sts_clr = '0;
        thr_is_clr = '0;
        oc_clr = '0;
        short_clr = '0;
        if (wr && addr_hit(wb_adr_i, ADDR_BRG_CLR)) begin
            thr_sts_clr = wm[THR_STS_MSB:THR_STS_LSB];
            thr_is_clr = wm[THR_IS_MSB:THR_IS_LSB];
            oc_clr = wm[OC_MSB:OC_LSB];
            short_clr = wm[SHORT_MSB:SHORT_LSB];
        end
    end

    // Supply interrupt flag clears
    always_comb begin
        sup_clr = '0;
        if (wr && addr_hit(wb_adr_i, ADDR_SUP_CLR)) begin
            sup_clr = wm[SUP_IS_MSB:SUP_IS_LSB];
        end
    end

    // Unimplemented analog sources never raise a flag
    affc_flag_bank #(.W(SYS_W), .EDGE(1'b1)) u_sys (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(sys_cond_i & SYS_IMPL),
        .clr_i(sys_clr),
        .flags_o(sys_flags),
        .set_o(sys_set)
    );

    // Threshold warning status re-sets each cycle while the warning lasts, then holds until cleared
    affc_flag_bank #(.W(THR_W), .EDGE(1'b0)) u_thr_sts (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(thr_cond_i),
        .clr_i(thr_sts_clr),
        .flags_o(thr_sts),
        .set_o(thr_sts_set)
    );

    affc_flag_bank #(.W(THR_W), .EDGE(1'b1)) u_thr_is (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(thr_cond_i),
        .clr_i(thr_is_clr),
        .flags_o(thr_is),
        .set_o(thr_set)
    );

    affc_flag_bank #(.W(FET_W), .EDGE(1'b1)) u_oc (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(fet_oc_i),
        .clr_i(oc_clr),
        .flags_o(oc_flags),
        .set_o(oc_set)
    );

    affc_flag_bank #(.W(FET_W), .EDGE(1'b1)) u_short (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(predrv_short_i),
        .clr_i(short_clr),
        .flags_o(short_flags),
        .set_o(short_set)
    );

    assign sup_cond = {supply_over_i, supply_under_i};

    affc_flag_bank #(.W(SUP_W), .EDGE(1'b1)) u_sup (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .cond_i(sup_cond),
        .clr_i(sup_clr),
        .flags_o(sup_is),
        .set_o(sup_set)
    );

    // Live supply status, one cycle behind the condition
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sup_sts_q <= '0;
        end else begin
            sup_sts_q <= sup_cond;
        end
    end

    // Enable registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sys_en_q <= '0;
            brg_en_q <= WORD_ZERO;
            sup_en_q <= SUP_EN_RESET;
        end else if (wr) begin
            if (addr_hit(wb_adr_i, ADDR_SYS_EN)) begin
                sys_en_q <= ((sys_en_q & ~lm[SYS_W-1:0]) | wm[SYS_W-1:0]) & SYS_IMPL;
            end else if (addr_hit(wb_adr_i, ADDR_BRG_EN)) begin
                brg_en_q <= ((brg_en_q & ~lm) | wm) & BRG_EN_IMPL;
            end else if (addr_hit(wb_adr_i, ADDR_SUP_EN)) begin
                sup_en_q <= (sup_en_q & ~lm[SUP_W-1:0]) | wm[SUP_W-1:0];
            end
        end
    end

    // Bridge status word with fixed ones and zeroed reserved ranges
    always_comb begin
        brg_word = BRG_STS_RESET;
        brg_word[THR_STS_MSB:THR_STS_LSB] = thr_sts;
        brg_word[THR_IS_MSB:THR_IS_LSB] = thr_is;
        brg_word[OC_MSB:OC_LSB] = oc_flags;
        brg_word[SHORT_MSB:SHORT_LSB] = short_flags;
    end

    // Read decode; clear registers read as zero, unmapped reads as zero
    always_comb begin
        rd_data = WORD_ZERO;
        if (addr_hit(wb_adr_i, ADDR_SYS_STS)) begin
            rd_data[SYS_W-1:0] = sys_flags;
        end else if (addr_hit(wb_adr_i, ADDR_SYS_EN)) begin
            rd_data[SYS_W-1:0] = sys_en_q;
        end else if (addr_hit(wb_adr_i, ADDR_SUP_STS)) begin
            rd_data[SUP_STS_MSB:SUP_STS_LSB] = sup_sts_q;
            rd_data[SUP_IS_MSB:SUP_IS_LSB] = sup_is;
        end else if (addr_hit(wb_adr_i, ADDR_SUP_EN)) begin
            rd_data[SUP_W-1:0] = sup_en_q;
        end else if (addr_hit(wb_adr_i, ADDR_BRG_STS)) begin
            rd_data = brg_word;
        end else if (addr_hit(wb_adr_i, ADDR_BRG_EN)) begin
            rd_data = brg_en_q;
        end else if (addr_hit(wb_adr_i, ADDR_SUM)) begin
            rd_data[SUM_W-1:0] = sum_q;
        end else if (addr_hit(wb_adr_i, ADDR_SUM_MASK)) begin
            rd_data[SUM_W-1:0] = sum_mask_q;
        end
    end

    // Read data is sampled with the request and held under ack
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            dat_q <= WORD_ZERO;
        end else if (req && !wb_we_i) begin
            dat_q <= rd_data;
        end
    end

    assign wb_dat_o = dat_q;

    // Summary: new events per group, cleared by reading
    assign sum_set[SUM_SYS] = |sys_set;
    assign sum_set[SUM_BRG] = |{thr_set, oc_set, short_set};
    assign sum_set[SUM_SUP] = |sup_set;
    // Only bits that were returned are cleared, so a late event is kept
    assign sum_clr = (rd && addr_hit(wb_adr_i, ADDR_SUM)) ? dat_q[SUM_W-1:0] : '0;

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sum_q <= '0;
        end else begin
            sum_q <= (sum_q & ~sum_clr) | sum_set;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            sum_mask_q <= '0;
        end else if (wr && addr_hit(wb_adr_i, ADDR_SUM_MASK) && wb_sel_i[0]) begin
            sum_mask_q <= wb_dat_i[SUM_W-1:0];
        end
    end

    // Registered interrupt outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            analog_irq_q <= 1'b0;
            bridge_irq_q <= 1'b0;
            supply_irq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            analog_irq_q <= |(sys_flags & sys_en_q);
            bridge_irq_q <= |(brg_word & brg_en_q);
            supply_irq_q <= |(sup_is & sup_en_q);
            irq_q <= |(sum_q & sum_mask_q);
        end
    end

    assign analog_irq_o = analog_irq_q;
    assign bridge_irq_o = bridge_irq_q;
    assign supply_irq_o = supply_irq_q;
    assign irq_o = irq_q;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);

    a_temp_clear: assert property ($past(sys_clr[SYS_TEMP_MSB:SYS_TEMP_LSB]) != 0 && !rst_i
        |-> (sys_flags[SYS_TEMP_MSB:SYS_TEMP_LSB] & $past(sys_clr[SYS_TEMP_MSB:SYS_TEMP_LSB])
            & ~$past(sys_set[SYS_TEMP_MSB:SYS_TEMP_LSB])) == 0)
        else $error("temperature flag not cleared");

    a_ref_clear: assert property (wr && addr_hit(wb_adr_i, ADDR_SYS_CLR)
        && wm[SYS_REF_LSB] && !sys_set[SYS_REF_LSB] |=> !sys_flags[SYS_REF_LSB])
        else $error("reference flag not cleared");

    a_lin_clear: assert property (wr && addr_hit(wb_adr_i, ADDR_SYS_CLR)
        && !wm[SYS_LIN_LSB] && sys_flags[SYS_LIN_LSB] |=> sys_flags[SYS_LIN_LSB])
        else $error("zero write changed LIN flag");

    a_brg_fixed: assert property (addr_hit(wb_adr_i, ADDR_BRG_STS) && req && !wb_we_i
        |=> wb_dat_o[5:4] == 2'b11 && (wb_dat_o & BRG_RSVD) == WORD_ZERO)
        else $error("bridge status fixed bits wrong");

    a_thr_level: assert property (thr_cond_i != 0
        |=> (thr_sts & $past(thr_cond_i)) == $past(thr_cond_i))
        else $error("threshold status missed a warning");

    a_thr_edge: assert property ($stable(thr_cond_i) && thr_is_clr == 0
        |=> $stable(thr_is))
        else $error("threshold flag moved without an edge");

    a_oc_clear: assert property (oc_clr[0] && !oc_set[0] |=> !oc_flags[0])
        else $error("overcurrent flag not cleared");

    a_short_wins: assert property (short_set[SHORT_MSB] && short_clr[SHORT_MSB]
        |=> short_flags[SHORT_MSB] [*1] ##0 short_flags[SHORT_MSB])
        else $error("short event lost under clear");

    a_sup_follow: assert property (##1 sup_sts_q == $past(sup_cond))
        else $error("supply status does not follow");

    a_irq_gate: assert property (sys_flags == 0 ##1 sys_flags == 0 |-> !analog_irq_o)
        else $error("analog interrupt without flag");

    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    c_sum_read: cover property (sum_q != 0 ##1 rd && addr_hit(wb_adr_i, ADDR_SUM));
    c_set_clear: cover property (thr_set != 0 && thr_is_clr != 0);
    c_irq_rise: cover property (!irq_o ##1 irq_o);
endmodule // affc_unit

// ===== verification/affc_host_model.sv
// Processor-side classic Wishbone master model for the fault flag unit.
// Assumes the slave answers with a registered ack sampled on the rising edge.
module affc_host_model (
    // Clock
    input wire logic mclk_i,
    // Wishbone master
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [7:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_i
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        wb_cyc_o = 1'b0;
        wb_stb_o = 1'b0;
        wb_we_o = 1'b0;
        wb_adr_o = 8'h00;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h00000000;
    end

    // Released lines show the inverse, so a stale value never passes for a fresh one
    task automatic access(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                          input logic [31:0] wdat, output logic [31:0] rdat, output logic ok);
        @(posedge mclk_i);
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o <= we;
        wb_adr_o <= adr;
        wb_sel_o <= sel;
        wb_dat_o <= wdat;
        // No cycle limit here: only the bench timeout ends a wait
        do begin
            @(posedge mclk_i);
        end while (wb_ack_i !== 1'b1);
        rdat = wb_dat_i;
        ok = (wb_ack_i === 1'b1);
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        wb_we_o <= ~we;
        wb_adr_o <= ~adr;
        wb_sel_o <= ~sel;
        wb_dat_o <= ~wdat;
    endtask
endmodule // affc_host_model

// ===== verification/tb_top.sv
// Self-checking bench for the analog fault flag unit.
// Assumes the host model owns the bus; the bench drives the fault conditions.
module tb_top
    import affc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i;
    logic rst_i;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_wdat, wb_rdat;
    logic [15:0] sys_c;
    logic [4:0] thr_c;
    logic [3:0] oc_c, sh_c, sup_o, sup_u;
    logic analog_irq_o, bridge_irq_o, supply_irq_o, irq_o;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'habbc;

    affc_host_model host (.mclk_i(mclk_i), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
        .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_wdat), .wb_dat_i(wb_rdat), .wb_ack_i(wb_ack));

    affc_unit dut (.mclk_i(mclk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .sys_cond_i(sys_c), .thr_cond_i(thr_c), .fet_oc_i(oc_c), .predrv_short_i(sh_c),
        .supply_over_i(sup_o), .supply_under_i(sup_u), .analog_irq_o(analog_irq_o),
        .bridge_irq_o(bridge_irq_o), .supply_irq_o(supply_irq_o), .irq_o(irq_o));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic [31:0] brg_word(input logic [4:0] t, input logic [4:0] ti,
                                             input logic [3:0] oc, input logic [3:0] sh);
        return {3'h0, t, 3'h0, ti, 2'h0, oc, 4'h0, 2'h3, sh};
    endfunction

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] v);
        logic [31:0] d;
        logic ok;
        host.access(1'b1, a, s, v, d, ok);
        if (!ok) fails++;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        host.access(1'b0, a, 4'hf, 32'h0, d, ok);
        if (!ok) fails++;
        check(d, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge mclk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            wrap_up();
        end
    end

    initial begin
        logic [31:0] v, m, e;
        logic [3:0] s;
        rst_i = 1'b1;
        sys_c = '0;
        thr_c = '0;
        oc_c = '0;
        sh_c = '0;
        sup_o = '0;
        sup_u = '0;
        tick(3);
        rst_i <= 1'b0;
        tick(1);
        rdchk(ADDR_BRG_STS, BRG_STS_RESET);
        rdchk(ADDR_SUP_STS, WORD_ZERO);
        rdchk(ADDR_SYS_STS, WORD_ZERO);
        // All-ones corner first, random vectors after
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hffffffff : rnd();
            sys_c <= v[15:0];
            tick(2);
            sys_c <= '0;
            tick(2);
            e = {16'h0, v[15:0] & SYS_IMPL};
            rdchk(ADDR_SYS_STS, e);
            wr(ADDR_SYS_CLR, 4'hf, 32'h0);
            rdchk(ADDR_SYS_STS, e);
            m = rnd();
            s = (i == 0) ? 4'hf : v[19:16];
            wr(ADDR_SYS_CLR, s, m);
            rdchk(ADDR_SYS_STS, e & ~(m & lanes(s)));
            wr(ADDR_SYS_CLR, 4'hf, 32'hffffffff);
            rdchk(ADDR_SYS_STS, WORD_ZERO);
        end
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 32'hffffffff : rnd();
            thr_c <= v[4:0];
            oc_c <= v[8:5];
            sh_c <= v[12:9];
            tick(2);
            thr_c <= '0;
            oc_c <= '0;
            sh_c <= '0;
            tick(2);
            e = brg_word(v[4:0], v[4:0], v[8:5], v[12:9]);
            rdchk(ADDR_BRG_STS, e);
            m = rnd();
            s = (i == 0) ? 4'hf : v[16:13];
            wr(ADDR_BRG_CLR, s, m);
            rdchk(ADDR_BRG_STS, (e & ~(m & lanes(s))) | BRG_STS_RESET);
            wr(ADDR_BRG_CLR, 4'hf, 32'hffffffff);
            rdchk(ADDR_BRG_STS, BRG_STS_RESET);
        end
        wr(ADDR_BRG_STS, 4'hf, 32'hffffffff);
        rdchk(ADDR_BRG_STS, BRG_STS_RESET);
        rdchk(ADDR_BRG_CLR, WORD_ZERO);
        // Held conditions: level status re-sets, edge flags do not
        thr_c <= 5'h1f;
        sys_c <= SYS_IMPL;
        tick(3);
        wr(ADDR_BRG_CLR, 4'hf, 32'hffffffff);
        wr(ADDR_SYS_CLR, 4'hf, 32'hffffffff);
        rdchk(ADDR_BRG_STS, brg_word(5'h1f, 5'h0, 4'h0, 4'h0));
        rdchk(ADDR_SYS_STS, WORD_ZERO);
        thr_c <= '0;
        sys_c <= '0;
        tick(2);
        wr(ADDR_BRG_CLR, 4'hf, 32'hffffffff);
        rdchk(ADDR_BRG_STS, BRG_STS_RESET);
        sup_o <= 4'ha;
        sup_u <= 4'h5;
        tick(3);
        rdchk(ADDR_SUP_STS, 32'h00a500a5);
        sup_o <= '0;
        sup_u <= '0;
        tick(3);
        rdchk(ADDR_SUP_STS, 32'h000000a5);
        check(supply_irq_o, 1'b1);
        wr(ADDR_SUP_CLR, 4'hf, 32'h000000ff);
        rdchk(ADDR_SUP_STS, WORD_ZERO);
        check(supply_irq_o, 1'b0);
        sys_c <= 16'h0001;
        tick(2);
        sys_c <= '0;
        tick(3);
        check(analog_irq_o, 1'b0);
        wr(ADDR_SYS_EN, 4'hf, 32'h00000001);
        tick(3);
        check(analog_irq_o, 1'b1);
        wr(ADDR_SUM_MASK, 4'hf, 32'h00000001);
        tick(3);
        check(irq_o, 1'b1);
        // Analog, bridge and supply groups have all had events since reset
        rdchk(ADDR_SUM, 32'h00000007);
        wr(ADDR_SYS_CLR, 4'hf, 32'h00000001);
        tick(3);
        check(analog_irq_o, 1'b0);
        check(irq_o, 1'b0);
        wr(ADDR_SYS_EN, 4'hf, 32'h00000000);
        rdchk(ADDR_SYS_EN, WORD_ZERO);
        wr(ADDR_BRG_EN, 4'hf, 32'hffffffff);
        rdchk(ADDR_BRG_EN, BRG_EN_IMPL);
        sh_c <= 4'h1;
        tick(2);
        sh_c <= '0;
        tick(3);
        check(bridge_irq_o, 1'b1);
        wr(ADDR_BRG_CLR, 4'hf, 32'h00000001);
        tick(3);
        check(bridge_irq_o, 1'b0);
        // Short event rises at the very edge where the clear lands
        fork
            wr(ADDR_BRG_CLR, 4'hf, 32'h0000000f);
            begin
                do begin
                    @(posedge mclk_i);
                end while (!wb_cyc || wb_ack);
                sh_c <= 4'h8;
            end
        join
        sh_c <= '0;
        rdchk(ADDR_BRG_STS, BRG_STS_RESET | 32'h00000008);
        wr(ADDR_BRG_CLR, 4'hf, 32'h0000000f);
        rdchk(ADDR_BRG_STS, BRG_STS_RESET);
        rdchk(8'h40, WORD_ZERO);
        wrap_up();
    end
endmodule // tb_top
